// ===== sefb_frame_builder.sv
// status and event frame builder with its output byte fifo
// assumes request sources and the framing stage run on the same clock
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// byte fifo with registered output stage
// ----------------------------------------------------------------
module sefb_fifo #(
  parameter int WIDTH = sefb_pkg::SEFB_FIFO_WIDTH,
  parameter int DEPTH = sefb_pkg::SEFB_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // the output stage keeps the top-level stream outputs on flip-flops
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end
    else if (pop)
    begin
      out_valid_reg <= 1'b1;
      out_data_reg <= mem[rd_ptr_reg];
    end
    else if (out_ready)
    begin
      out_valid_reg <= 1'b0;
    end
  end
endmodule : sefb_fifo

// ----------------------------------------------------------------
// frame builder top
// ----------------------------------------------------------------
module sefb_frame_builder (
  input wire logic clock,
  input wire logic reset,
  input wire logic tx_req_valid,
  input wire logic [7:0] tx_req_tag,
  input wire logic [sefb_pkg::SEFB_CAUSE_W-1:0] tx_req_cause,
  output logic tx_req_ready,
  input wire logic fw_update_active,
  input wire logic [sefb_pkg::SEFB_NUM_MODEM_EV-1:0] modem_event,
  input wire logic radio_connect,
  input wire logic radio_disconnect,
  input wire logic framed_host_mode,
  input wire logic radio_unlocked,
  input wire logic sms_valid,
  input wire logic [sefb_pkg::SEFB_NUM_W-1:0] sms_number,
  output logic sms_ready,
  input wire logic body_valid,
  input wire logic [7:0] body_data,
  input wire logic body_last,
  output logic body_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  import sefb_pkg::*;

  // maps a cause number to its status byte; out of range reads as unknown
  function automatic logic [7:0] tx_code(input logic [SEFB_CAUSE_W-1:0] cause,
                                         input logic busy);
    logic [SEFB_CAUSE_W-1:0] idx;
    idx = (int'(cause) < SEFB_NUM_CAUSES) ? cause : SEFB_CAUSE_UNKNOWN;
    tx_code = busy ? SEFB_TX_UPDATE_BUSY : SEFB_TX_CODE[idx];
  endfunction : tx_code

  // lowest set bit wins
  function automatic logic [3:0] first_set(input logic [SEFB_NUM_EV-1:0] v);
    first_set = 4'h0;
    for (int i = SEFB_NUM_EV - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        first_set = 4'(i);
      end
    end
  endfunction : first_set

  // blanks every byte after the first null so the field is zero padded
  function automatic logic [SEFB_NUM_W-1:0] pad_number(input logic [SEFB_NUM_W-1:0] n);
    logic seen;
    seen = 1'b0;
    pad_number = n;
    for (int i = SEFB_NUM_BYTES - 1; i >= 0; i--)
    begin
      if (seen)
      begin
        pad_number[i*8 +: 8] = SEFB_PAD_BYTE;
      end
      if (n[i*8 +: 8] == SEFB_PAD_BYTE)
      begin
        seen = 1'b1;
      end
    end
  endfunction : pad_number

  sefb_state_t state_reg;
  logic tx_req_ready_reg;
  logic tx_pend_reg;
  logic [7:0] tx_tag_reg;
  logic [7:0] tx_code_reg;
  logic [SEFB_NUM_EV-1:0] ev_pend_reg;
  logic [SEFB_NUM_EV-1:0] ev_set;
  logic [SEFB_NUM_EV-1:0] ev_clr;
  logic sms_ready_reg;
  logic sms_pend_reg;
  logic [SEFB_NUM_W-1:0] sms_num_reg;
  logic body_ready_reg;
  logic hold_valid_reg;
  logic [7:0] hold_data_reg;
  logic hold_last_reg;
  logic [7:0] frame_a_reg;
  logic [7:0] frame_b_reg;
  logic [4:0] idx_reg;
  logic wr_valid;
  logic [7:0] wr_data;
  logic wr_last;
  logic wr_ready;
  logic wr_take;
  logic [SEFB_FIFO_WIDTH-1:0] fifo_out;
  logic [3:0] ev_pick;

  assign tx_req_ready = tx_req_ready_reg;
  assign sms_ready = sms_ready_reg;
  assign body_ready = body_ready_reg;
  assign wr_take = wr_valid && wr_ready;
  assign ev_pick = first_set(ev_pend_reg);

  // ----------------------------------------------------------------
  // transmit status requests
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tx_req_ready_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      tx_tag_reg <= '0;
      tx_code_reg <= '0;
    end
    else if (tx_req_ready_reg && tx_req_valid)
    begin
      tx_req_ready_reg <= 1'b0;
      tx_pend_reg <= (tx_req_tag != SEFB_TAG_NONE);
      tx_tag_reg <= tx_req_tag;
      tx_code_reg <= tx_code(tx_req_cause, fw_update_active);
    end
    else
    begin
      tx_req_ready_reg <= !tx_pend_reg;
      if (state_reg == ST_IDLE)
      begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // modem events: sticky until sent, a new event beats the clear
  // ----------------------------------------------------------------
  always_comb
  begin
    ev_set = '0;
    ev_set[SEFB_NUM_MODEM_EV-1:0] = modem_event;
    ev_set[SEFB_EV_RADIO_UP] = radio_connect && framed_host_mode && radio_unlocked;
    ev_set[SEFB_EV_RADIO_DOWN] = radio_disconnect && framed_host_mode && radio_unlocked;
    ev_clr = '0;
    if (state_reg == ST_IDLE && !tx_pend_reg && ev_pend_reg != '0)
    begin
      ev_clr[ev_pick] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ev_pend_reg <= '0;
    end
    else
    begin
      ev_pend_reg <= (ev_pend_reg & ~ev_clr) | ev_set;
    end
  end

  // ----------------------------------------------------------------
  // text message requests and body holding register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sms_ready_reg <= 1'b0;
      sms_pend_reg <= 1'b0;
      sms_num_reg <= '0;
    end
    else if (sms_ready_reg && sms_valid)
    begin
      sms_ready_reg <= 1'b0;
      sms_pend_reg <= 1'b1;
      sms_num_reg <= pad_number(sms_number);
    end
    else
    begin
      sms_ready_reg <= !sms_pend_reg;
      if (state_reg == ST_SMS_BODY && wr_take && hold_last_reg)
      begin
        sms_pend_reg <= 1'b0;
      end
    end
  end

  // body intake of at most one byte every three cycles keeps body_ready on a flip-flop
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      body_ready_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_data_reg <= '0;
      hold_last_reg <= 1'b0;
    end
    else
    begin
      if (body_ready_reg && body_valid)
      begin
        body_ready_reg <= 1'b0;
        hold_valid_reg <= 1'b1;
        hold_data_reg <= body_data;
        hold_last_reg <= body_last;
      end
      else
      begin
        body_ready_reg <= (state_reg == ST_SMS_BODY) && !hold_valid_reg;
        if (state_reg == ST_SMS_BODY && wr_take)
        begin
          hold_valid_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sequencer: transmit status first, then events, then text
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      frame_a_reg <= '0;
      frame_b_reg <= '0;
      idx_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          idx_reg <= '0;
          if (tx_pend_reg)
          begin
            frame_a_reg <= tx_tag_reg;
            frame_b_reg <= tx_code_reg;
            state_reg <= ST_TX_TYPE;
          end
          else if (ev_pend_reg != '0)
          begin
            frame_b_reg <= SEFB_MODEM_CODE[ev_pick];
            state_reg <= ST_MS_TYPE;
          end
          else if (sms_pend_reg)
          begin
            state_reg <= ST_SMS_TYPE;
          end
        end
        ST_TX_TYPE: if (wr_take) state_reg <= ST_TX_TAG;
        ST_TX_TAG: if (wr_take) state_reg <= ST_TX_CODE;
        ST_TX_CODE: if (wr_take) state_reg <= ST_IDLE;
        ST_MS_TYPE: if (wr_take) state_reg <= ST_MS_CODE;
        ST_MS_CODE: if (wr_take) state_reg <= ST_IDLE;
        ST_SMS_TYPE: if (wr_take) state_reg <= ST_SMS_NUM;
        ST_SMS_NUM:
        begin
          if (wr_take)
          begin
            idx_reg <= idx_reg + 1'b1;
            if (int'(idx_reg) == SEFB_NUM_BYTES - 1)
            begin
              state_reg <= ST_SMS_BODY;
            end
          end
        end
        ST_SMS_BODY: if (wr_take && hold_last_reg) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // byte offered to the fifo in each frame state (none in idle), last marks the frame end
  always_comb
  begin
    wr_valid = 1'b1;
    wr_data = '0;
    wr_last = 1'b0;
    case (state_reg)
      ST_TX_TYPE: wr_data = SEFB_TYPE_TX_STATUS;
      ST_TX_TAG: wr_data = frame_a_reg;
      ST_TX_CODE:
      begin
        wr_data = frame_b_reg;
        wr_last = 1'b1;
      end
      ST_MS_TYPE: wr_data = SEFB_TYPE_MODEM;
      ST_MS_CODE:
      begin
        wr_data = frame_b_reg;
        wr_last = 1'b1;
      end
      ST_SMS_TYPE: wr_data = SEFB_TYPE_SMS;
      ST_SMS_NUM: wr_data = sms_num_reg[SEFB_NUM_W-1-8*int'(idx_reg) -: 8];
      ST_SMS_BODY:
      begin
        wr_valid = hold_valid_reg;
        wr_data = hold_data_reg;
        wr_last = hold_last_reg;
      end
      default: wr_valid = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // output fifo toward the framing stage
  // ----------------------------------------------------------------
  sefb_fifo #(
    .WIDTH(SEFB_FIFO_WIDTH),
    .DEPTH(SEFB_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(wr_valid),
    .in_data({wr_last, wr_data}),
    .in_ready(wr_ready),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out)
  );

  assign out_data = fifo_out[7:0];
  assign out_last = fifo_out[8];
endmodule : sefb_frame_builder

`default_nettype wire

// ===== sefb_pkg.sv
// constants, frame codes and state type for the status and event frame builder
// assumes a single 250 MHz clock domain shared with the framing stage
package sefb_pkg;

  // ----------------------------------------------------------------
  // frame type bytes, the pad byte and the empty tag
  // ----------------------------------------------------------------
  localparam logic [7:0] SEFB_TYPE_TX_STATUS = 8'h89;
  localparam logic [7:0] SEFB_TYPE_MODEM = 8'h8a;
  localparam logic [7:0] SEFB_TYPE_SMS = 8'h9f;
  localparam logic [7:0] SEFB_PAD_BYTE = 8'h00;
  localparam logic [7:0] SEFB_TAG_NONE = 8'h00;

  // ----------------------------------------------------------------
  // transmit status codes, indexed by cause number
  // ----------------------------------------------------------------
  localparam int SEFB_NUM_CAUSES = 28;
  localparam int SEFB_CAUSE_W = 5;
  localparam logic [4:0] SEFB_CAUSE_UNKNOWN = 5'h15;
  localparam logic [7:0] SEFB_TX_CODE [SEFB_NUM_CAUSES] = '{
    8'h00, 8'h20, 8'h21, 8'h22, 8'h2c, 8'h31, 8'h32,
    8'h74, 8'h76, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
    8'h7d, 8'h7e, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84,
    8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b
  };
  localparam logic [7:0] SEFB_TX_UPDATE_BUSY = 8'h7e;

  // ----------------------------------------------------------------
  // modem status codes, indexed by event line
  // ----------------------------------------------------------------
  localparam int SEFB_NUM_MODEM_EV = 9;
  localparam int SEFB_NUM_EV = 11;
  localparam int SEFB_EV_RADIO_UP = 9;
  localparam int SEFB_EV_RADIO_DOWN = 10;
  localparam logic [7:0] SEFB_MODEM_CODE [SEFB_NUM_EV] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h0e, 8'h0f,
    8'h38, 8'h39, 8'h3a, 8'h32, 8'h33
  };

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SEFB_NUM_BYTES = 20;
  localparam int SEFB_NUM_W = SEFB_NUM_BYTES * 8;
  localparam int SEFB_FIFO_WIDTH = 9;
  localparam int SEFB_FIFO_DEPTH = 32;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_TX_TYPE,
    ST_TX_TAG,
    ST_TX_CODE,
    ST_MS_TYPE,
    ST_MS_CODE,
    ST_SMS_TYPE,
    ST_SMS_NUM,
    ST_SMS_BODY
  } sefb_state_t;

endpackage : sefb_pkg

// ===== sefb_frame_builder_asserts.sv
// checker for the frame builder request handshakes and output byte stream
// assumes one clock domain and is bound onto every builder instance
`timescale 1ns/1ps
`default_nettype none

module sefb_frame_builder_asserts
  import sefb_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic tx_req_valid,
  input wire logic [7:0] tx_req_tag,
  input wire logic [SEFB_CAUSE_W-1:0] tx_req_cause,
  input wire logic tx_req_ready,
  input wire logic sms_valid,
  input wire logic sms_ready,
  input wire logic body_valid,
  input wire logic body_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready
);
  // ----------------------------------------------------------------
  // position of the current byte within its frame
  // ----------------------------------------------------------------
  logic [7:0] pos_reg;
  logic [7:0] type_reg;
  logic zero_reg;
  logic [7:0] cur_type;
  logic take;
  assign take = out_valid && out_ready;
  assign cur_type = (pos_reg == 8'h00) ? out_data : type_reg;

  always_ff @(posedge clock)
  begin
    if (reset || (take && out_last))
      pos_reg <= 8'h00;
    else if (take)
      pos_reg <= pos_reg + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (take && pos_reg == 8'h00)
      type_reg <= out_data;
  end

  // once a pad byte is seen every later number byte must be a pad too
  always_ff @(posedge clock)
  begin
    if (reset || pos_reg == 8'h00)
      zero_reg <= 1'b0;
    else if (take && out_data == SEFB_PAD_BYTE)
      zero_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0) reset |=>
    !out_valid && !tx_req_ready && !sms_ready && !body_ready) else $error("outputs busy in reset");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
    && $stable(out_last)) else $error("stalled output byte changed");
  a_tx_ready_drop: assert property (tx_req_valid && tx_req_ready |=> !tx_req_ready)
    else $error("transmit ready stayed high after take");
  a_sms_ready_drop: assert property (sms_valid && sms_ready |=> !sms_ready)
    else $error("text ready stayed high after take");
  a_body_half_rate: assert property (body_valid && body_ready |=> !body_ready)
    else $error("body taken on consecutive cycles");
  a_frame_type: assert property (out_valid && pos_reg == 8'h00 |-> out_data inside
    {8'h89, 8'h8a, 8'h9f}) else $error("frame starts with unknown type byte");
  a_tx_length: assert property (out_valid && cur_type == 8'h89 |->
    out_last == (pos_reg == 8'h02)) else $error("transmit status frame not three bytes");
  a_modem_length: assert property (out_valid && cur_type == 8'h8a |->
    out_last == (pos_reg == 8'h01)) else $error("modem status frame not two bytes");
  a_tx_tag_zero: assert property (tx_req_valid && tx_req_ready && tx_req_tag == 8'h00 |=>
    ##1 tx_req_ready) else $error("zero tag request left a frame pending");
  a_sms_length: assert property (out_valid && cur_type == 8'h9f && pos_reg <= 8'h14 |->
    !out_last) else $error("text frame ended inside header");
  a_sms_pad: assert property (out_valid && cur_type == 8'h9f && pos_reg >= 8'h02
    && pos_reg <= 8'h14 && zero_reg |-> out_data == 8'h00) else $error("number not padded");
endmodule : sefb_frame_builder_asserts

bind sefb_frame_builder sefb_frame_builder_asserts chk (.clock(clock), .reset(reset),
  .tx_req_valid(tx_req_valid), .tx_req_tag(tx_req_tag), .tx_req_cause(tx_req_cause),
  .tx_req_ready(tx_req_ready), .sms_valid(sms_valid), .sms_ready(sms_ready),
  .body_valid(body_valid), .body_ready(body_ready), .out_valid(out_valid),
  .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

`default_nettype wire

// ===== sefb_host_model.sv
// host side sink for the frame byte stream
// assumes the bench reads rx_q; stalls one cycle in four and while hold is high
`timescale 1ns/1ps
`default_nettype none

module sefb_host_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic hold,
  output logic out_ready
);
  logic [8:0] rx_q[$];
  logic [1:0] gap_reg;

  initial out_ready = 1'b0;

  // ready changes just after the edge so the builder sees a settled level
  always @(posedge clock)
  begin
    if (!reset && out_valid && out_ready)
      rx_q.push_back({out_last, out_data});
    gap_reg <= reset ? 2'h0 : gap_reg + 2'h1;
    #1;
    out_ready = !reset && !hold && gap_reg != 2'h3;
  end
endmodule : sefb_host_model

`default_nettype wire

// ===== sefb_tb.sv
// self-checking bench for the status and event frame builder
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sefb_pkg::*;
  logic clock, reset, tx_req_valid, tx_req_ready, fw_update_active;
  logic radio_connect, radio_disconnect, framed_host_mode, radio_unlocked;
  logic sms_valid, sms_ready, body_valid, body_last, body_ready;
  logic out_valid, out_last, out_ready, host_hold;
  logic [7:0] tx_req_tag, body_data, out_data;
  logic [SEFB_CAUSE_W-1:0] tx_req_cause;
  logic [SEFB_NUM_MODEM_EV-1:0] modem_event;
  logic [SEFB_NUM_W-1:0] sms_number;
  logic [8:0] exp_q[$];
  int miscompares, checks_done;

  sefb_frame_builder dut (.clock(clock), .reset(reset), .tx_req_valid(tx_req_valid),
    .tx_req_tag(tx_req_tag), .tx_req_cause(tx_req_cause), .tx_req_ready(tx_req_ready),
    .fw_update_active(fw_update_active), .modem_event(modem_event),
    .radio_connect(radio_connect), .radio_disconnect(radio_disconnect),
    .framed_host_mode(framed_host_mode), .radio_unlocked(radio_unlocked),
    .sms_valid(sms_valid), .sms_number(sms_number), .sms_ready(sms_ready),
    .body_valid(body_valid), .body_data(body_data), .body_last(body_last),
    .body_ready(body_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready));
  sefb_host_model host (.clock(clock), .reset(reset), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .hold(host_hold), .out_ready(out_ready));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n >= 900)
    begin
      miscompares++;
      $display("BAD wait expected 1 seen 0");
      final_report();
    end
  endtask : guard

  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick

  function automatic logic sig(input int k);
    return (k == 0) ? tx_req_ready : (k == 1) ? sms_ready : body_ready;
  endfunction : sig

  // ready is read at the edge, before that edge's updates land
  task automatic wait_hi(input int k);
    int n;
    @(posedge clock);
    for (n = 0; n < 900 && sig(k) !== 1'b1; n++)
      @(posedge clock);
    guard(n);
  endtask : wait_hi

  function automatic void put(input logic [7:0] b, input logic last);
    exp_q.push_back({last, b});
  endfunction : put

  task automatic check_rx();
    int n;
    for (n = 0; n < 900 && host.rx_q.size() < exp_q.size(); n++)
      @(posedge clock);
    guard(n);
    repeat (40) @(posedge clock);
    chk("frame byte count", 9'(exp_q.size()), 9'(host.rx_q.size()));
    while (exp_q.size() > 0 && host.rx_q.size() > 0)
      chk("frame byte", exp_q.pop_front(), host.rx_q.pop_front());
    exp_q.delete();
    host.rx_q.delete();
  endtask : check_rx

  task automatic send_tx(input logic [7:0] tag, input logic [4:0] cause, input logic fw);
    tick();
    tx_req_valid = 1'b1;
    tx_req_tag = tag;
    tx_req_cause = cause;
    fw_update_active = fw;
    wait_hi(0);
    #1;
    tx_req_valid = 1'b0;
    fw_update_active = 1'b0;
  endtask : send_tx

  task automatic radio(input logic c, input logic d, input logic m, input logic u);
    tick();
    framed_host_mode = m;
    radio_unlocked = u;
    radio_connect = c;
    radio_disconnect = d;
    tick();
    radio_connect = 1'b0;
    radio_disconnect = 1'b0;
  endtask : radio

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_causes();
    logic [7:0] code [28] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h2c, 8'h31, 8'h32, 8'h74,
      8'h76, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80, 8'h81, 8'h82, 8'h83,
      8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b};
    for (int c = 0; c < 28; c++)
    begin
      send_tx(8'(c + 1), 5'(c), 1'b0);
      put(8'h89, 1'b0);
      put(8'(c + 1), 1'b0);
      put(code[c], 1'b1);
    end
    check_rx();
  endtask : t_causes

  task automatic t_tag_update();
    send_tx(8'h00, 5'h01, 1'b0);
    send_tx(8'h55, 5'h02, 1'b0);
    send_tx(8'h66, 5'h00, 1'b1);
    send_tx(8'h77, 5'h1f, 1'b0);
    put(8'h89, 1'b0);
    put(8'h55, 1'b0);
    put(8'h21, 1'b1);
    put(8'h89, 1'b0);
    put(8'h66, 1'b0);
    put(8'h7e, 1'b1);
    // a cause past the table end reports the unknown error code
    put(8'h89, 1'b0);
    put(8'h77, 1'b0);
    put(8'h85, 1'b1);
    check_rx();
  endtask : t_tag_update

  task automatic t_modem();
    logic [7:0] code [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0e, 8'h0f, 8'h38, 8'h39, 8'h3a};
    for (int i = 0; i < 9; i++)
    begin
      tick();
      modem_event = 9'(1 << i);
      tick();
      modem_event = 9'h000;
      put(8'h8a, 1'b0);
      put(code[i], 1'b1);
    end
    check_rx();
  endtask : t_modem

  task automatic t_radio();
    radio(1'b1, 1'b0, 1'b0, 1'b1);
    radio(1'b0, 1'b1, 1'b1, 1'b0);
    radio(1'b1, 1'b0, 1'b1, 1'b1);
    radio(1'b0, 1'b1, 1'b1, 1'b1);
    put(8'h8a, 1'b0);
    put(8'h32, 1'b1);
    put(8'h8a, 1'b0);
    put(8'h33, 1'b1);
    check_rx();
  endtask : t_radio

  // the host stalls long enough that the fifo fills and body bytes are refused
  task automatic t_sms();
    int n;
    host_hold = 1'b1;
    tick();
    for (n = 0; n < 20; n++)
      sms_number[159 - 8 * n -: 8] = (n < 7) ? 8'(8'h31 + n) : (n == 8) ? 8'h77 : 8'h00;
    sms_valid = 1'b1;
    wait_hi(1);
    #1;
    sms_valid = 1'b0;
    put(8'h9f, 1'b0);
    for (n = 0; n < 20; n++)
      put((n < 7) ? 8'(8'h31 + n) : 8'h00, 1'b0);
    fork
      for (n = 0; n < 40; n++)
      begin
        body_valid = 1'b1;
        body_data = 8'(8'ha0 + n);
        body_last = (n == 39);
        wait_hi(2);
        put(body_data, body_last);
        #1;
      end
      begin
        repeat (300) @(posedge clock);
        chk("body refused", 9'h000, {8'h00, body_ready});
        chk("body stopped early", 9'h001, {8'h00, n < 40});
        chk("host stalled", 9'h000, 9'(host.rx_q.size()));
        #1;
        host_hold = 1'b0;
      end
    join
    body_valid = 1'b0;
    body_last = 1'b0;
    check_rx();
  endtask : t_sms

  task automatic t_reset();
    reset = 1'b1;
    tick();
    tick();
    chk("ready in reset", 9'h000, {8'h00, tx_req_ready});
    reset = 1'b0;
    // read at the edge itself, so each check sees what that edge samples
    @(posedge clock);
    chk("ready one edge after release", 9'h000, {8'h00, tx_req_ready});
    chk("text ready one edge after release", 9'h000, {8'h00, sms_ready});
    @(posedge clock);
    chk("ready two edges after release", 9'h001, {8'h00, tx_req_ready});
    chk("text ready two edges after release", 9'h001, {8'h00, sms_ready});
    #1;
  endtask : t_reset

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial
  begin
    reset = 1'b1;
    {tx_req_valid, fw_update_active, radio_connect, radio_disconnect} = 4'h0;
    {framed_host_mode, radio_unlocked, sms_valid, body_valid, body_last} = 5'h00;
    {tx_req_tag, tx_req_cause, modem_event, body_data, host_hold} = '0;
    sms_number = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    tick();
    tick();
    t_causes();
    t_tag_update();
    t_modem();
    t_radio();
    t_sms();
    t_reset();
    final_report();
  end
endmodule : tb

`default_nettype wire
